//--- pkg/ccsu_pkg.sv
`default_nettype none
package ccsu_pkg;
   // ==========================================
   // Status byte layout
   localparam int unsigned   BIT_QSB    = 3;
   localparam int unsigned   BIT_MAV    = 4;
   localparam int unsigned   BIT_ESB    = 5;
   localparam int unsigned   BIT_MSS    = 6;
   localparam int unsigned   BIT_OSB    = 7;
   localparam logic [7:0]    STB_USED   = 8'hB8;
   localparam logic [7:0]    SRE_USED   = 8'hB8;
   localparam logic [7:0]    SRE_RESET  = 8'h00;
   localparam logic [7:0]    STB_RESET  = 8'h00;
   // ==========================================
   // Nonvolatile register numbers
   localparam logic [7:0]    NV_AUTO    = 8'h00;
   localparam logic [7:0]    NV_SAV_MIN = 8'h01;
   localparam logic [7:0]    NV_MAX     = 8'h14;
   // ==========================================
   // Error codes, two's complement
   localparam logic [15:0]   ERR_TRIG   = 16'hFF20;
   localparam logic [15:0]   ERR_RANGE  = 16'hFF22;
   localparam logic [15:0]   ERR_STEST  = 16'hFEB6;
   localparam logic [15:0]   ERR_QUERY  = 16'hFE48;
   // ==========================================
   // ASCII
   localparam logic [7:0]    A_ZERO     = 8'h30;
   localparam logic [7:0]    A_ONE      = 8'h31;
   localparam logic [7:0]    A_THREE    = 8'h33;
   localparam logic [7:0]    A_COMMA    = 8'h2C;
   localparam logic [7:0]    A_NL       = 8'h0A;
   localparam logic [3:0]    REP_DEPTH  = 4'h8;
   // ==========================================
   // Commands from the parser
   typedef enum logic [3:0] {
      C_OPCQ = 4'h0, C_OPC  = 4'h1, C_OPTQ = 4'h2, C_PMC  = 4'h3,
      C_RCL  = 4'h4, C_RST  = 4'h5, C_SAV  = 4'h6, C_SREW = 4'h7,
      C_SREQ = 4'h8, C_STBQ = 4'h9, C_TRG  = 4'hA, C_GET  = 4'hB,
      C_TSTQ = 4'hC, C_DDT  = 4'hD, C_EMC  = 4'hE, C_NOP  = 4'hF
   } ccsu_cmd_t;
   // Device trigger actions; codes above T_NONE are illegal
   typedef enum logic [1:0] {
      T_INIT = 2'h0, T_READ = 2'h1, T_FETCH = 2'h2, T_NONE = 2'h3
   } ccsu_trg_t;
   localparam logic [7:0]    TRG_MAX    = 8'h03;
   // Timebase strap: 0 none, 1 medium, 2 or 3 high
   localparam logic [1:0]    TB_NONE    = 2'h0;
   localparam logic [1:0]    TB_MED     = 2'h1;
   localparam logic [1:0]    RF_NONE    = 2'h0;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01, S_OPCQ = 6'h02, S_SEND = 6'h04,
      S_TST  = 6'h08, S_RSAV = 6'h10, S_NVW  = 6'h20
   } ccsu_state_t;
endpackage
`default_nettype wire

//--- pkg/ccsu_sb_if.sv
`default_nettype none
interface ccsu_sb_if;
   logic [7:0] service_request_enable_mask;
   logic       qsb;
   logic       message_available_bit;
   logic       event_summary_bit;
   logic       osb;
   logic [7:0] stb;
   logic [7:0] spoll;
   logic       srq;
   modport ctl (output service_request_enable_mask, output qsb, output message_available_bit, output event_summary_bit, output osb,
                input stb, input spoll, input srq);
   modport sb  (input service_request_enable_mask, input qsb, input message_available_bit, input event_summary_bit, input osb,
                output stb, output spoll, output srq);
endinterface
`default_nettype wire

//--- hw/ccsu_status_byte.sv
`default_nettype none
module ccsu_status_byte
   import ccsu_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst,
   ccsu_sb_if.sb     sb
);
   typedef struct packed {
      logic [7:0] stb;
      logic [7:0] spoll;
      logic       srq;
   } ccsu_sbs_t;

   ccsu_sbs_t  s_r;
   ccsu_sbs_t  s_nxt;
   logic [7:0] raw;
   logic       master_summary_bit;

   // ==========================================
   // Summary and request
   always_comb begin
      raw = '0;
      raw[BIT_QSB] = sb.qsb;
      raw[BIT_MAV] = sb.message_available_bit;
      raw[BIT_ESB] = sb.event_summary_bit;
      raw[BIT_OSB] = sb.osb;
      master_summary_bit = |(raw & sb.service_request_enable_mask & STB_USED);
      s_nxt = s_r;
      s_nxt.stb = raw;
      s_nxt.stb[BIT_MSS] = master_summary_bit;
      s_nxt.srq = master_summary_bit;
      s_nxt.spoll = raw;
      s_nxt.spoll[BIT_MSS] = master_summary_bit;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '{stb: STB_RESET, spoll: STB_RESET, srq: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sb.stb   = s_r.stb;
   assign sb.spoll = s_r.spoll;
   assign sb.srq   = s_r.srq;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_mss_summary: assert property (
      1'b1 |=> s_r.stb[BIT_MSS] == |($past(raw) & $past(sb.service_request_enable_mask) & STB_USED))
      else $error("master summary does not match masked status");
   a_srq_follows: assert property (
      $rose(s_r.stb[BIT_MSS]) |-> s_r.srq ##1 (s_r.srq == s_r.stb[BIT_MSS]))
      else $error("service request not tracking summary");
endmodule
`default_nettype wire

//--- hw/ccsu_top.sv
`default_nettype none
module ccsu_top
   import ccsu_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               dev_clr,
   input  wire logic               cmd_valid,
   input  wire ccsu_pkg::ccsu_cmd_t cmd_code,
   input  wire logic [7:0]         cmd_arg,
   input  wire logic               cmd_last,
   output logic                    cmd_ready,
   input  wire logic               meas_busy,
   output logic [7:0]              oq_data,
   output logic                    oq_valid,
   output logic                    oq_eoi,
   input  wire logic               oq_ready,
   output logic                    err_valid,
   output logic [15:0]             err_code,
   output logic                    esr_opc_set,
   input  wire logic               qsb,
   input  wire logic               event_summary_bit,
   input  wire logic               osb,
   output logic [7:0]              service_request_enable_mask,
   output logic [7:0]              stb,
   output logic [7:0]              spoll_byte,
   output logic                    srq,
   output logic                    macro_en,
   output logic                    macro_purge,
   output logic                    settings_rst,
   output logic                    keyq_clr,
   output logic                    trg_init,
   output logic                    trg_read,
   output logic                    trg_fetch,
   output logic                    nv_save,
   output logic                    nv_recall,
   output logic [7:0]              nv_reg,
   input  wire logic               nv_done,
   output logic                    st_start,
   input  wire logic               st_done,
   input  wire logic               st_fail,
   input  wire logic [1:0]         opt_tb_pin,
   input  wire logic [1:0]         opt_rf_pin
);
   import ccsu_pkg::*;

   typedef struct packed {
      ccsu_state_t     st;
      logic            busy_prev;
      logic            opc_arm;
      logic            macro_en;
      ccsu_trg_t       trg_def;
      logic [7:0]      service_request_enable_mask;
      logic [7:0][7:0] rep;
      logic [3:0]      rep_len;
      logic [3:0]      rep_idx;
      logic [7:0]      oq_data;
      logic            oq_valid;
      logic            oq_eoi;
      logic            err_valid;
      logic [15:0]     err_code;
      logic            opc_set;
      logic            purge;
      logic            set_rst;
      logic            keyq_clr;
      logic            t_init;
      logic            t_read;
      logic            t_fetch;
      logic            nv_save;
      logic            nv_recall;
      logic [7:0]      nv_reg;
      logic [7:0]      rcl_reg;
      logic            st_start;
      logic            rdy;
      logic [3:0]      opt_s1;
      logic [3:0]      opt_s2;
   } ccsu_top_s_t;

   ccsu_top_s_t s_r;
   ccsu_top_s_t s_nxt;
   logic        acc;
   logic        fall;
   logic        fire;
   logic [3:0]  k;
   logic [7:0]  v;
   logic [1:0]  tb;
   logic [1:0]  rf;

   ccsu_sb_if sbi ();

   ccsu_status_byte u_sb (
      .clk_sys (clk_sys),
      .rst     (rst),
      .sb      (sbi.sb)
   );

   assign sbi.service_request_enable_mask = s_r.service_request_enable_mask;
   assign sbi.qsb = qsb;
   assign sbi.event_summary_bit = event_summary_bit;
   assign sbi.osb = osb;
   // Unread byte on the port or still buffered
   assign sbi.message_available_bit = s_r.oq_valid | (s_r.st == S_SEND);

   // ==========================================
   // Next state
   always_comb begin
      k    = '0;
      v    = '0;
      tb   = s_r.opt_s2[1:0];
      rf   = s_r.opt_s2[3:2];
      acc  = cmd_valid & s_r.rdy & ~dev_clr;
      fall = s_r.busy_prev & ~meas_busy;
      fire = 1'b0;
      s_nxt = s_r;
      s_nxt.busy_prev = meas_busy;
      s_nxt.opt_s1    = {opt_rf_pin, opt_tb_pin};
      s_nxt.opt_s2    = s_r.opt_s1;
      s_nxt.err_valid = 1'b0;
      s_nxt.opc_set   = 1'b0;
      s_nxt.purge     = 1'b0;
      s_nxt.set_rst   = 1'b0;
      s_nxt.keyq_clr  = 1'b0;
      s_nxt.t_init    = 1'b0;
      s_nxt.t_read    = 1'b0;
      s_nxt.t_fetch   = 1'b0;
      s_nxt.nv_save   = 1'b0;
      s_nxt.nv_recall = 1'b0;
      s_nxt.st_start  = 1'b0;
      if (s_r.oq_valid && oq_ready) begin
         s_nxt.oq_valid = 1'b0;
      end
      if (s_r.opc_arm && fall) begin
         s_nxt.opc_set = 1'b1;
         s_nxt.opc_arm = 1'b0;
      end

      unique case (s_r.st)
         S_IDLE: begin
            if (acc) begin
               unique case (cmd_code)
                  C_OPCQ: s_nxt.st = S_OPCQ;
                  C_OPC: s_nxt.opc_arm = 1'b1;
                  C_OPTQ: begin
                     s_nxt.rep[0] = A_ZERO;
                     k = 4'h1;
                     if (tb != TB_NONE) begin
                        s_nxt.rep[1] = (tb == TB_MED) ? A_ZERO : A_ONE;
                        s_nxt.rep[2] = (tb == TB_MED) ? A_ONE : A_ZERO;
                        k = 4'h3;
                     end
                     s_nxt.rep[k[2:0]] = A_COMMA;
                     s_nxt.rep[k[2:0] + 3'h1] = A_ZERO;
                     k = k + 4'h2;
                     if (rf != RF_NONE) begin
                        s_nxt.rep[k[2:0] - 3'h1] = A_ZERO;
                        s_nxt.rep[k[2:0]] = A_THREE;
                        s_nxt.rep[k[2:0] + 3'h1] = A_ZERO;
                        k = k + 4'h2;
                     end
                     s_nxt.rep[k[2:0]] = A_NL;
                     s_nxt.rep_len = k + 4'h1;
                     s_nxt.rep_idx = '0;
                     s_nxt.st = S_SEND;
                     if (!cmd_last) begin
                        s_nxt.err_valid = 1'b1;
                        s_nxt.err_code  = ERR_QUERY;
                     end
                  end
                  C_PMC: s_nxt.purge = 1'b1;
                  C_RCL: begin
                     if (cmd_arg <= NV_MAX) begin
                        s_nxt.nv_save = 1'b1;
                        s_nxt.nv_reg  = NV_AUTO;
                        s_nxt.rcl_reg = cmd_arg;
                        s_nxt.st      = S_RSAV;
                     end else begin
                        s_nxt.err_valid = 1'b1;
                        s_nxt.err_code  = ERR_RANGE;
                     end
                  end
                  C_SAV: begin
                     if (cmd_arg >= NV_SAV_MIN && cmd_arg <= NV_MAX) begin
                        s_nxt.nv_save = 1'b1;
                        s_nxt.nv_reg  = cmd_arg;
                        s_nxt.st      = S_NVW;
                     end else begin
                        s_nxt.err_valid = 1'b1;
                        s_nxt.err_code  = ERR_RANGE;
                     end
                  end
                  C_RST: begin
                     // Mask, output queue and holdoffs outside this set stay put
                     s_nxt.set_rst  = 1'b1;
                     s_nxt.macro_en = 1'b0;
                     s_nxt.opc_arm  = 1'b0;
                     s_nxt.keyq_clr = 1'b1;
                     s_nxt.trg_def  = T_INIT;
                  end
                  C_SREW: s_nxt.service_request_enable_mask = cmd_arg & SRE_USED;
                  C_SREQ, C_STBQ: begin
                     // Reads only the registered byte; no side effects
                     v = (cmd_code == C_SREQ) ? s_r.service_request_enable_mask : sbi.stb;
                     s_nxt.rep[0] = A_ZERO + 8'(v / 8'h64);
                     s_nxt.rep[1] = A_ZERO + 8'((v / 8'h0A) % 8'h0A);
                     s_nxt.rep[2] = A_ZERO + 8'(v % 8'h0A);
                     s_nxt.rep[3] = A_NL;
                     s_nxt.rep_len = 4'h4;
                     s_nxt.rep_idx = (v >= 8'h64) ? 4'h0 : (v >= 8'h0A) ? 4'h1 : 4'h2;
                     s_nxt.st = S_SEND;
                  end
                  C_TRG, C_GET: fire = 1'b1;
                  C_TSTQ: begin
                     s_nxt.st_start = 1'b1;
                     s_nxt.st = S_TST;
                  end
                  C_DDT: begin
                     if (cmd_arg <= TRG_MAX) begin
                        s_nxt.trg_def = ccsu_trg_t'(cmd_arg[1:0]);
                     end else begin
                        s_nxt.err_valid = 1'b1;
                        s_nxt.err_code  = ERR_TRIG;
                     end
                  end
                  C_EMC: s_nxt.macro_en = |cmd_arg;
                  C_NOP: ;
               endcase
            end
         end
         S_OPCQ: begin
            // Only a falling edge of meas_busy, device clear (below) or power-on leaves here
            if (fall) begin
               s_nxt.rep[0]  = A_ONE;
               s_nxt.rep[1]  = A_NL;
               s_nxt.rep_len = 4'h2;
               s_nxt.rep_idx = '0;
               s_nxt.st      = S_SEND;
            end
         end
         S_SEND: begin
            if (!s_r.oq_valid || oq_ready) begin
               s_nxt.oq_data  = s_r.rep[s_r.rep_idx[2:0]];
               s_nxt.oq_valid = 1'b1;
               s_nxt.oq_eoi   = (s_r.rep_idx == s_r.rep_len - 4'h1);
               s_nxt.rep_idx  = s_r.rep_idx + 4'h1;
               if (s_r.rep_idx == s_r.rep_len - 4'h1) begin
                  s_nxt.st = S_IDLE;
               end
            end
         end
         S_TST: begin
            if (st_done) begin
               s_nxt.rep[0]  = st_fail ? A_ONE : A_ZERO;
               s_nxt.rep[1]  = A_NL;
               s_nxt.rep_len = 4'h2;
               s_nxt.rep_idx = '0;
               s_nxt.st      = S_SEND;
               if (st_fail) begin
                  s_nxt.err_valid = 1'b1;
                  s_nxt.err_code  = ERR_STEST;
               end
            end
         end
         S_RSAV: begin
            if (nv_done) begin
               s_nxt.nv_recall = 1'b1;
               s_nxt.nv_reg    = s_r.rcl_reg;
               s_nxt.st        = S_NVW;
            end
         end
         S_NVW: begin
            if (nv_done) begin
               s_nxt.st = S_IDLE;
            end
         end
         default: s_nxt.st = S_IDLE;
      endcase

      if (fire) begin
         unique case (s_r.trg_def)
            T_INIT: s_nxt.t_init = 1'b1;
            T_READ: s_nxt.t_read = 1'b1;
            T_FETCH: s_nxt.t_fetch = 1'b1;
            T_NONE: ;
         endcase
      end
      if (dev_clr) begin
         s_nxt.st       = S_IDLE;
         s_nxt.opc_arm  = 1'b0;
         s_nxt.oq_valid = 1'b0;
      end
      s_nxt.rdy = (s_nxt.st == S_IDLE);
   end

   // ==========================================
   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r          <= '0;
         s_r.st       <= S_IDLE;
         s_r.trg_def  <= T_INIT;
         s_r.service_request_enable_mask      <= SRE_RESET;
         s_r.rep_len  <= REP_DEPTH;
         s_r.rdy      <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cmd_ready    = s_r.rdy;
   assign oq_data      = s_r.oq_data;
   assign oq_valid     = s_r.oq_valid;
   assign oq_eoi       = s_r.oq_eoi;
   assign err_valid    = s_r.err_valid;
   assign err_code     = s_r.err_code;
   assign esr_opc_set  = s_r.opc_set;
   assign service_request_enable_mask          = s_r.service_request_enable_mask;
   assign stb          = sbi.stb;
   assign spoll_byte   = sbi.spoll;
   assign srq          = sbi.srq;
   assign macro_en     = s_r.macro_en;
   assign macro_purge  = s_r.purge;
   assign settings_rst = s_r.set_rst;
   assign keyq_clr     = s_r.keyq_clr;
   assign trg_init     = s_r.t_init;
   assign trg_read     = s_r.t_read;
   assign trg_fetch    = s_r.t_fetch;
   assign nv_save      = s_r.nv_save;
   assign nv_recall    = s_r.nv_recall;
   assign nv_reg       = s_r.nv_reg;
   assign st_start     = s_r.st_start;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence q_rcl_take;
      acc && cmd_code == C_RCL && cmd_arg <= NV_MAX;
   endsequence
   sequence q_rcl_first_save;
      nv_save && nv_reg == NV_AUTO && !nv_recall;
   endsequence

   a_opcq_reply: assert property (
      (s_r.st == S_OPCQ && fall && !dev_clr) |=> s_r.st == S_SEND ##1
      (oq_valid && oq_data == A_ONE))
      else $error("operation-complete reply not a single 1");
   a_holdoff_keep: assert property (
      (s_r.st == S_OPCQ && !fall && !dev_clr) |=> s_r.st == S_OPCQ)
      else $error("holdoff released without cause");
   a_opcq_no_bit: assert property (
      (s_r.st == S_OPCQ && !s_r.opc_arm) |=> !esr_opc_set)
      else $error("query changed the operation-complete bit");
   a_opt_last_err: assert property (
      (acc && cmd_code == C_OPTQ && !cmd_last) |=> err_valid && err_code == ERR_QUERY)
      else $error("missing -440 on option query");
   a_sre_write: assert property (
      (acc && cmd_code == C_SREW) |=> service_request_enable_mask == ($past(cmd_arg) & SRE_USED) && !service_request_enable_mask[BIT_MSS])
      else $error("enable mask write wrong");
   a_rst_keeps_sre: assert property (
      (acc && cmd_code inside {C_RST, C_SAV, C_RCL}) |=> service_request_enable_mask == $past(service_request_enable_mask))
      else $error("mask disturbed by reset, save or recall");
   a_rcl_save0: assert property (
      q_rcl_take |=> q_rcl_first_save)
      else $error("recall did not save register 0 first");
   a_tst_fail_err: assert property (
      (s_r.st == S_TST && st_done && st_fail && !dev_clr) |=>
      err_valid && err_code == ERR_STEST ##1 oq_data != A_ZERO)
      else $error("self-test failure not reported");
   a_trg_init: assert property (
      (acc && cmd_code inside {C_TRG, C_GET} && s_r.trg_def == T_INIT) |=> trg_init)
      else $error("trigger did not initiate");
   a_opc_event: assert property (
      (s_r.opc_arm && fall && !dev_clr) |=> esr_opc_set && !s_r.opc_arm)
      else $error("armed completion missed");
endmodule
`default_nettype wire

//--- tb/ccsu_far_model.sv
`default_nettype none
module ccsu_far_model (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic nv_req,
   input  wire logic st_start,
   input  wire logic fail_sel,
   output logic      oq_ready,
   output logic      nv_done,
   output logic      st_done,
   output logic      st_fail
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] nv_sh;
   logic [5:0] st_sh;
   initial {oq_ready, nv_sh, st_sh} = '0;
   // ==========================
   // Reader stalls at random so replies see back-pressure
   always @(posedge clk_sys) begin
      oq_ready <= #1 !rst && $urandom_range(1, 0);
      nv_sh <= #1 rst ? 4'h0 : {nv_sh[2:0], nv_req};
      st_sh <= #1 rst ? 6'h0 : {st_sh[4:0], st_start};
   end
   assign nv_done = nv_sh[3];
   assign st_done = st_sh[5];
   assign st_fail = st_done & fail_sel;
endmodule
`default_nettype wire

//--- tb/common_command_status_unit_test.sv
`default_nettype none
module common_command_status_unit_test;
   import ccsu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, dev_clr, cmd_valid, cmd_last, cmd_ready, meas_busy, oq_valid;
   logic oq_eoi, oq_ready, err_valid, esr_opc_set, qsb, event_summary_bit, osb, srq, trg_init, trg_read;
   logic trg_fetch, nv_save, nv_recall, nv_done, st_start, st_done, st_fail, fsel;
   logic macro_en, macro_purge, settings_rst, keyq_clr;
   logic [7:0] cmd_arg, oq_data, service_request_enable_mask, stb, spoll_byte, nv_reg;
   logic [15:0] err_code, last_err;
   logic [1:0] opt_tb_pin, opt_rf_pin;
   logic [8:0] nq[$];
   ccsu_cmd_t cmd_code;
   int fails, samples_checked, v, e, m, n_opc, n_trg[3], n_prg, n_srst, n_kq;
   string s, x, y;
   ccsu_top i_ccsu_top (.clk_sys(clk_sys), .rst(rst), .dev_clr(dev_clr), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
      .meas_busy(meas_busy), .oq_data(oq_data), .oq_valid(oq_valid), .oq_eoi(oq_eoi),
      .oq_ready(oq_ready), .err_valid(err_valid), .err_code(err_code),
      .esr_opc_set(esr_opc_set), .qsb(qsb), .event_summary_bit(event_summary_bit), .osb(osb), .service_request_enable_mask(service_request_enable_mask), .stb(stb),
      .spoll_byte(spoll_byte), .srq(srq), .macro_en(macro_en), .macro_purge(macro_purge),
      .settings_rst(settings_rst), .keyq_clr(keyq_clr), .trg_init(trg_init),
      .trg_read(trg_read), .trg_fetch(trg_fetch), .nv_save(nv_save), .nv_recall(nv_recall),
      .nv_reg(nv_reg), .nv_done(nv_done), .st_start(st_start), .st_done(st_done),
      .st_fail(st_fail), .opt_tb_pin(opt_tb_pin), .opt_rf_pin(opt_rf_pin));
   ccsu_far_model i_ccsu_far_model (.clk_sys(clk_sys), .rst(rst),
      .nv_req(nv_save | nv_recall), .st_start(st_start), .fail_sel(fsel),
      .oq_ready(oq_ready), .nv_done(nv_done), .st_done(st_done), .st_fail(st_fail));
   task automatic chk(string n, logic [15:0] ex, logic [15:0] got);
      samples_checked++;
      if (got !== ex) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, ex, got);
      end
   endtask
   task automatic chks(string n, string ex, string got);
      samples_checked++;
      if (got != ex) begin
         fails++;
         $display("MISMATCH %s exp %s got %s", n, ex, got);
      end
   endtask
   task automatic send(ccsu_cmd_t c, logic [7:0] a);
      @(posedge clk_sys) #1;
      cmd_valid = 1;
      cmd_code = c;
      cmd_arg = a;
      do @(negedge clk_sys); while (cmd_ready !== 1'b1);
      @(posedge clk_sys) #1;
      cmd_valid = 0;
   endtask
   task automatic rd(output string r);
      int k;
      r = "";
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
         if (oq_valid === 1'b1 && oq_ready === 1'b1) r = $sformatf("%s%c", r, oq_data);
      end while (!(oq_valid === 1'b1 && oq_ready === 1'b1 && oq_eoi === 1'b1) && k < 400);
   endtask
   task automatic tally_and_finish();
      $display("checked %0d failed %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================
   // Event log of the one-cycle pulses
   always @(negedge clk_sys) begin
      if (esr_opc_set === 1'b1) n_opc++;
      if (trg_init === 1'b1) n_trg[0]++;
      if (trg_read === 1'b1) n_trg[1]++;
      if (trg_fetch === 1'b1) n_trg[2]++;
      if (macro_purge === 1'b1) n_prg++;
      if (settings_rst === 1'b1) n_srst++;
      if (keyq_clr === 1'b1) n_kq++;
      if (err_valid === 1'b1) last_err = err_code;
      if (nv_save === 1'b1) nq.push_back({1'b0, nv_reg});
      if (nv_recall === 1'b1) nq.push_back({1'b1, nv_reg});
   end
   initial begin
      clk_sys = 0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(99041));
      {rst, dev_clr, cmd_valid, meas_busy, qsb, event_summary_bit, osb, fsel} = 8'h80;
      {cmd_arg, opt_tb_pin, opt_rf_pin} = '0;
      cmd_code = C_NOP;
      cmd_last = 1;
      repeat (2) @(posedge clk_sys);
      #1 rst = 0;
      @(negedge clk_sys);
      chk("sre", SRE_RESET, service_request_enable_mask);
      chk("stb", STB_RESET, stb);
      for (int i = 0; i < 12; i++) begin
         v = $urandom_range(255, 0);
         send(C_SREW, v[7:0]);
         {qsb, event_summary_bit, osb} = $urandom_range(7, 0);
         repeat (3) @(negedge clk_sys);
         e = {osb, 1'b0, event_summary_bit, 1'b0, qsb, 3'h0};
         m = |(e & v & 8'hB8);
         chk("sre", v & 8'hB8, service_request_enable_mask);
         chk("stb", e | (m << 6), stb);
         chk("srq", m, srq);
         chk("spoll", e | (m << 6), spoll_byte);
      end
      send(C_SREQ, 0);
      rd(s);
      chks("sreq", $sformatf("%0d\n", v & 8'hB8), s);
      // Let the message-available bit of the last reply drain first
      repeat (2) @(posedge clk_sys);
      send(C_STBQ, 0);
      rd(s);
      chks("stbq", $sformatf("%0d\n", e | (m << 6)), s);
      repeat (3) @(negedge clk_sys);
      chk("stb", e | (m << 6), stb);
      $display("test status done");
      for (int t = 0; t < 4; t++) for (int r = 0; r < 3; r++) begin
         @(posedge clk_sys) #1;
         opt_tb_pin = t[1:0];
         opt_rf_pin = r[1:0];
         repeat (3) @(posedge clk_sys);
         send(C_OPTQ, 0);
         rd(s);
         x = "010";
         if (t == 0) x = "0";
         if (t == 1) x = "001";
         y = ",0\n";
         if (r != 0) y = ",030\n";
         chks("opt", {x, y}, s);
      end
      @(posedge clk_sys) #1 cmd_last = 0;
      send(C_OPTQ, 0);
      rd(s);
      chks("opt", "010,030\n", s);
      chk("err", ERR_QUERY, last_err);
      @(posedge clk_sys) #1 cmd_last = 1;
      $display("test option done");
      @(posedge clk_sys) #1 meas_busy = 1;
      send(C_OPCQ, 0);
      repeat (20) @(negedge clk_sys);
      chk("held", 0, oq_valid);
      @(posedge clk_sys) #1 meas_busy = 0;
      rd(s);
      chks("opcq", "1\n", s);
      chk("opcbit", 0, n_opc);
      @(posedge clk_sys) #1 meas_busy = 1;
      send(C_OPC, 0);
      @(posedge clk_sys) #1 meas_busy = 0;
      repeat (4) @(negedge clk_sys);
      chk("opcbit", 1, n_opc);
      @(posedge clk_sys) #1 meas_busy = 1;
      send(C_OPCQ, 0);
      repeat (5) @(posedge clk_sys);
      #1 dev_clr = 1;
      @(posedge clk_sys) #1 dev_clr = 0;
      chk("ready", 1, cmd_ready);
      meas_busy = 0;
      repeat (8) @(negedge clk_sys);
      chk("clr", 0, oq_valid);
      $display("test complete done");
      for (int a = 0; a < 4; a++) begin
         send(C_DDT, a[7:0]);
         send(a[0] ? C_GET : C_TRG, 0);
      end
      send(C_EMC, 8'h01);
      chk("macro", 1, macro_en);
      send(C_PMC, 0);
      send(C_DDT, 8'h07);
      send(C_TRG, 0);
      send(C_RST, 0);
      send(C_TRG, 0);
      repeat (4) @(negedge clk_sys);
      chk("err", ERR_TRIG, last_err);
      chk("init", 2, n_trg[0]);
      chk("read", 1, n_trg[1]);
      chk("fetch", 1, n_trg[2]);
      chk("sre", v & 8'hB8, service_request_enable_mask);
      chk("macro", 0, macro_en);
      chk("purge", 1, n_prg);
      chk("setrst", 1, n_srst);
      chk("keyq", 1, n_kq);
      send(C_SAV, 8'h15);
      repeat (3) @(negedge clk_sys);
      chk("err", ERR_RANGE, last_err);
      send(C_SAV, 8'h14);
      send(C_RCL, 8'h05);
      send(C_NOP, 0);
      chk("nv", 9'h014, nq[0]);
      chk("nv", 9'h000, nq[1]);
      chk("nv", 9'h105, nq[2]);
      for (int f = 0; f < 2; f++) begin
         fsel = f[0];
         send(C_TSTQ, 0);
         rd(s);
         chks("tst", f ? "1\n" : "0\n", s);
      end
      chk("err", ERR_STEST, last_err);
      // Second power-on in mid-run: mask and status byte must clear
      @(posedge clk_sys) #1 rst = 1;
      repeat (2) @(posedge clk_sys);
      #1 rst = 0;
      @(negedge clk_sys);
      chk("sre", SRE_RESET, service_request_enable_mask);
      chk("stb", STB_RESET, stb);
      $display("test command done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
